// ---- verilog/dfm_pkg.sv ----
// constants and types shared by the drive fault manager
// Summary of operation
// - any error walks the drive through fault reaction into the fault state
// - each detected error stays latched until a fault reset or power-off
// - any latched error sets the summary error flag in the state register
// - per-error latched detail is readable over the register bus
// - fault reset clears an error only once its condition has gone
// - after a successful reset the drive rests in switch-on-disabled
// - following error can be masked; masked it neither stops motion nor latches
// - undervoltage keeps the drive not ready and has no mask
// - timer-qualified errors show a warning while their timer runs
// - over-temperature latches only after staying active longer than its time
// - field bus communication failure raises its own fault
// - deviation above the following-error limit raises the following fault
package dfm_pkg;

  // error source indices within the detail vector
  localparam int ERR_N         = 12;
  localparam int ERR_UNDERVOLT = 0;
  localparam int ERR_OVERVOLT  = 1;
  localparam int ERR_OVERCURR  = 2;
  localparam int ERR_BALLAST   = 3;
  localparam int ERR_FEEDBACK  = 4;
  localparam int ERR_I2T       = 5;
  localparam int ERR_FOLLOW    = 6;
  localparam int ERR_EEPROM    = 7;
  localparam int ERR_FIELDBUS  = 8;
  localparam int ERR_PROCEDURE = 9;
  localparam int ERR_OT_ELEC   = 10;
  localparam int ERR_OT_MOTOR  = 11;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATE      = 8'h04;
  localparam logic [7:0] OFS_DETAIL     = 8'h08;
  localparam logic [7:0] OFS_WARN       = 8'h0C;
  localparam logic [7:0] OFS_FOLLOW_LIM = 8'h10;
  localparam logic [7:0] OFS_OT_ELEC_T  = 8'h14;
  localparam logic [7:0] OFS_OT_MOTOR_T = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;

  // field positions
  localparam int CTRL_RESET_BIT  = 0;
  localparam int CTRL_SWON_BIT   = 1;
  localparam int CTRL_MASK_BIT   = 2;
  localparam int STATE_SUM_BIT   = 8;
  localparam int STATE_READY_BIT = 9;
  localparam int STATE_WARN_BIT  = 10;
  localparam int IRQ_FAULT_BIT   = 0;
  localparam int IRQ_WARN_BIT    = 1;
  localparam int IRQ_CLEAR_BIT   = 2;
  localparam int IRQ_W           = 3;

  // reset values
  localparam logic [31:0]      FOLLOW_LIM_RST = 32'h0000_1000;
  localparam logic [31:0]      OT_TIME_RST    = 32'h0000_2710;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST   = 3'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // fault reaction time: least time, rounded up to whole cycles
  localparam int CLK_NS       = 10;
  localparam int REACT_NS     = 50;
  localparam int REACT_CYCLES = (REACT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    DRV_DISABLED = 4'h1,
    DRV_READY    = 4'h2,
    DRV_REACT    = 4'h4,
    DRV_FAULT    = 4'h8
  } dfm_drive_type;

endpackage

// ---- verilog/dfm_err_latch.sv ----
// one sticky error bit: set wins over clear
`timescale 1ns/10ps
`default_nettype none
module dfm_err_latch (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // control
  input  wire logic set,
  input  wire logic clr,
  // latched bit
  output logic      q
);

  typedef struct packed {
    logic err;
  } dfm_latch_state_type;

  dfm_latch_state_type s;
  dfm_latch_state_type next_s;

  always_comb begin
    next_s     = s;
    next_s.err = set | (s.err & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign q = s.err;

endmodule
`default_nettype wire

// ---- verilog/dfm_qual_timer.sv ----
// qualification timer: warning while running, fault once expired
`timescale 1ns/10ps
`default_nettype none
module dfm_qual_timer #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // condition and programmed time in cycles
  input  wire logic             cond,
  input  wire logic [CNT_W-1:0] limit,
  // qualified results
  output logic                  warn,
  output logic                  fault
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } dfm_timer_state_type;

  dfm_timer_state_type s;
  dfm_timer_state_type next_s;

  // cnt holds the number of earlier consecutive active cycles
  always_comb begin
    next_s = s;
    if (!cond) begin
      next_s.cnt = '0;
    end else if (s.cnt != '1) begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // active for more than limit cycles
  assign fault = cond & (s.cnt >= limit);
  assign warn  = cond & ~fault;

endmodule
`default_nettype wire

// ---- verilog/dfm_top.sv ----
// drive fault manager with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
module dfm_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // error conditions, levels
  input  wire logic        under_volt,
  input  wire logic        over_volt,
  input  wire logic        over_curr,
  input  wire logic        ballast_err,
  input  wire logic        feedback_err,
  input  wire logic        i2t_err,
  input  wire logic        eeprom_err,
  input  wire logic        fieldbus_fail,
  input  wire logic        procedure_err,
  input  wire logic        ot_elec,
  input  wire logic        ot_motor,
  input  wire logic [31:0] pos_dev,
  // drive status
  output logic             drive_ready,
  output logic             fault_summary,
  output logic             stop_motion,
  output logic [1:0]       temp_warning,
  output logic             irq
);

  localparam int N = dfm_pkg::ERR_N;

  typedef struct packed {
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [1:0]                   rresp;
    logic [31:0]                  rdata;
    logic                         aw_held;
    logic                         w_held;
    logic [7:0]                   awaddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         mask_follow;
    logic [31:0]                  follow_lim;
    logic [31:0]                  ot_elec_t;
    logic [31:0]                  ot_motor_t;
    logic [dfm_pkg::IRQ_W-1:0]    irq_stat;
    logic [dfm_pkg::IRQ_W-1:0]    irq_mask;
    dfm_pkg::dfm_drive_type       drive;
    logic [2:0]                   react_cnt;
    logic                         summary;
    logic                         ready;
    logic                         stop;
    logic [1:0]                   warn;
    logic                         irq;
  } dfm_top_state_type;

  localparam dfm_top_state_type RST = '{
    drive:      dfm_pkg::DRV_DISABLED,
    follow_lim: dfm_pkg::FOLLOW_LIM_RST,
    ot_elec_t:  dfm_pkg::OT_TIME_RST,
    ot_motor_t: dfm_pkg::OT_TIME_RST,
    irq_mask:   dfm_pkg::IRQ_MASK_RST,
    default:    '0
  };

  dfm_top_state_type s;
  dfm_top_state_type next_s;

  logic [N-1:0]  cond;
  logic [N-1:0]  err_set;
  logic [N-1:0]  err_clr;
  logic [N-1:0]  err_q;
  logic [31:0]   dev_mag;
  logic [1:0]    q_warn;
  logic [1:0]    q_fault;
  logic          aw_fire;
  logic          w_fire;
  logic          ar_fire;
  logic          do_wr;
  logic [7:0]    wa;
  logic [7:0]    ra;
  logic [31:0]   wd;
  logic [3:0]    ws;
  logic          wr_reset;
  logic          wr_swon;
  logic          any_err;
  logic [31:0]   rd;
  logic          rd_ok;
  logic          wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // error conditions, one bit per source
  always_comb begin
    dev_mag                      = pos_dev[31] ? (~pos_dev + 32'h1) : pos_dev;
    cond                         = '0;
    cond[dfm_pkg::ERR_UNDERVOLT] = under_volt;
    cond[dfm_pkg::ERR_OVERVOLT]  = over_volt;
    cond[dfm_pkg::ERR_OVERCURR]  = over_curr;
    cond[dfm_pkg::ERR_BALLAST]   = ballast_err;
    cond[dfm_pkg::ERR_FEEDBACK]  = feedback_err;
    cond[dfm_pkg::ERR_I2T]       = i2t_err;
    // masking removes the condition itself, so motion is not stopped either
    cond[dfm_pkg::ERR_FOLLOW]    = (dev_mag > s.follow_lim) & ~s.mask_follow;
    cond[dfm_pkg::ERR_EEPROM]    = eeprom_err;
    cond[dfm_pkg::ERR_FIELDBUS]  = fieldbus_fail;
    cond[dfm_pkg::ERR_PROCEDURE] = procedure_err;
    cond[dfm_pkg::ERR_OT_ELEC]   = ot_elec;
    cond[dfm_pkg::ERR_OT_MOTOR]  = ot_motor;
    err_set                      = cond;
    err_set[dfm_pkg::ERR_OT_ELEC]  = q_fault[0];
    err_set[dfm_pkg::ERR_OT_MOTOR] = q_fault[1];
    err_clr = {N{wr_reset}} & ~cond;
  end

  dfm_qual_timer #(.CNT_W(32)) u_ot_elec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cond    (ot_elec),
    .limit   (s.ot_elec_t),
    .warn    (q_warn[0]),
    .fault   (q_fault[0])
  );

  dfm_qual_timer #(.CNT_W(32)) u_ot_motor (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .cond    (ot_motor),
    .limit   (s.ot_motor_t),
    .warn    (q_warn[1]),
    .fault   (q_fault[1])
  );

  for (genvar i = 0; i < N; i++) begin : g_err
    dfm_err_latch u_latch (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .set     (err_set[i]),
      .clr     (err_clr[i]),
      .q       (err_q[i])
    );
  end

  // bus decode
  always_comb begin
    aw_fire  = awvalid & s.awready;
    w_fire   = wvalid & s.wready;
    ar_fire  = arvalid & s.arready;
    do_wr    = (s.aw_held | aw_fire) & (s.w_held | w_fire) & ~s.bvalid;
    wa       = s.aw_held ? {s.awaddr[7:2], 2'b00} : {awaddr[7:2], 2'b00};
    wd       = s.w_held ? s.wdata : wdata;
    ws       = s.w_held ? s.wstrb : wstrb;
    ra       = {araddr[7:2], 2'b00};
    wr_reset = do_wr & (wa == dfm_pkg::OFS_CTRL) & ws[0] & wd[dfm_pkg::CTRL_RESET_BIT];
    wr_swon  = do_wr & (wa == dfm_pkg::OFS_CTRL) & ws[0] & wd[dfm_pkg::CTRL_SWON_BIT];
    any_err  = |err_q;
    wr_ok    = (wa == dfm_pkg::OFS_CTRL) | (wa == dfm_pkg::OFS_FOLLOW_LIM) | (wa == dfm_pkg::OFS_OT_ELEC_T)
             | (wa == dfm_pkg::OFS_OT_MOTOR_T) | (wa == dfm_pkg::OFS_IRQ_MASK);
    rd       = '0;
    rd_ok    = 1'b1;
    case (ra)
      dfm_pkg::OFS_CTRL:       rd[dfm_pkg::CTRL_MASK_BIT] = s.mask_follow;
      dfm_pkg::OFS_STATE: begin
        rd[3:0]                      = s.drive;
        rd[dfm_pkg::STATE_SUM_BIT]   = s.summary;
        rd[dfm_pkg::STATE_READY_BIT] = s.ready;
        rd[dfm_pkg::STATE_WARN_BIT]  = |s.warn;
      end
      dfm_pkg::OFS_DETAIL:     rd[N-1:0] = err_q;
      dfm_pkg::OFS_WARN:       rd[1:0] = s.warn;
      dfm_pkg::OFS_FOLLOW_LIM: rd = s.follow_lim;
      dfm_pkg::OFS_OT_ELEC_T:  rd = s.ot_elec_t;
      dfm_pkg::OFS_OT_MOTOR_T: rd = s.ot_motor_t;
      dfm_pkg::OFS_IRQ_STAT:   rd[dfm_pkg::IRQ_W-1:0] = s.irq_stat;
      dfm_pkg::OFS_IRQ_MASK:   rd[dfm_pkg::IRQ_W-1:0] = s.irq_mask;
      default:                 rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    logic [dfm_pkg::IRQ_W-1:0] ev;
    ev     = '0;
    next_s = s;
    // write channel: address and data taken in either order
    if (aw_fire) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = awaddr;
    end
    if (w_fire) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    if (s.bvalid & bready) begin
      next_s.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_ok ? dfm_pkg::RESP_OKAY : dfm_pkg::RESP_SLVERR;
      case (wa)
        dfm_pkg::OFS_CTRL: begin
          if (ws[0]) begin
            next_s.mask_follow = wd[dfm_pkg::CTRL_MASK_BIT];
          end
        end
        dfm_pkg::OFS_FOLLOW_LIM: next_s.follow_lim = merge(s.follow_lim, wd, ws);
        dfm_pkg::OFS_OT_ELEC_T:  next_s.ot_elec_t = merge(s.ot_elec_t, wd, ws);
        dfm_pkg::OFS_OT_MOTOR_T: next_s.ot_motor_t = merge(s.ot_motor_t, wd, ws);
        dfm_pkg::OFS_IRQ_MASK: begin
          if (ws[0]) begin
            next_s.irq_mask = wd[dfm_pkg::IRQ_W-1:0];
          end
        end
        default: next_s.bresp = wr_ok ? dfm_pkg::RESP_OKAY : dfm_pkg::RESP_SLVERR;
      endcase
    end
    next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_held & ~next_s.bvalid;
    // read channel
    if (s.rvalid & rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd;
      next_s.rresp  = rd_ok ? dfm_pkg::RESP_OKAY : dfm_pkg::RESP_SLVERR;
    end
    next_s.arready = ~next_s.rvalid;
    // drive state machine
    case (s.drive)
      dfm_pkg::DRV_DISABLED: begin
        if (any_err) begin
          next_s.drive = dfm_pkg::DRV_REACT;
        end else if (wr_swon & ~under_volt) begin
          // goes to ready only on an explicit switch-on command, and only without undervoltage
          next_s.drive = dfm_pkg::DRV_READY;
        end
      end
      dfm_pkg::DRV_READY: begin
        if (any_err) begin
          next_s.drive = dfm_pkg::DRV_REACT;
        end
      end
      dfm_pkg::DRV_REACT: begin
        next_s.react_cnt = s.react_cnt + 3'h1;
        if (s.react_cnt == 3'(dfm_pkg::REACT_CYCLES - 1)) begin
          next_s.react_cnt = '0;
          next_s.drive     = dfm_pkg::DRV_FAULT;
        end
      end
      dfm_pkg::DRV_FAULT: begin
        if (!any_err) begin
          next_s.drive = dfm_pkg::DRV_DISABLED;
          ev[dfm_pkg::IRQ_CLEAR_BIT] = 1'b1;
        end
      end
      default: next_s.drive = dfm_pkg::DRV_DISABLED;
    endcase
    ev[dfm_pkg::IRQ_FAULT_BIT] = (next_s.drive == dfm_pkg::DRV_REACT) & (s.drive != dfm_pkg::DRV_REACT);
    ev[dfm_pkg::IRQ_WARN_BIT]  = |(q_warn & ~s.warn);
    // read clears the status, a same-cycle event still sets it
    if (ar_fire && ra == dfm_pkg::OFS_IRQ_STAT) begin
      next_s.irq_stat = '0;
    end
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
    // status outputs
    next_s.summary = any_err;
    next_s.ready   = (next_s.drive == dfm_pkg::DRV_READY) & ~under_volt;
    next_s.stop    = (next_s.drive == dfm_pkg::DRV_REACT) | (next_s.drive == dfm_pkg::DRV_FAULT);
    next_s.warn    = q_warn;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign arready       = s.arready;
  assign rvalid        = s.rvalid;
  assign rresp         = s.rresp;
  assign rdata         = s.rdata;
  assign drive_ready   = s.ready;
  assign fault_summary = s.summary;
  assign stop_motion   = s.stop;
  assign temp_warning  = s.warn;
  assign irq           = s.irq;

  // checks
  localparam int REACT_D = dfm_pkg::REACT_CYCLES;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  chk_fault_entry: assert property ((s.drive == dfm_pkg::DRV_READY) && any_err |=> s.drive == dfm_pkg::DRV_REACT)
    else $error("error did not start fault reaction");
  chk_react_exit: assert property ($rose(s.drive == dfm_pkg::DRV_REACT) |-> ##[1:REACT_D] s.drive == dfm_pkg::DRV_FAULT)
    else $error("fault reaction did not reach fault state");
  chk_latch_hold: assert property (!wr_reset |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("latched error dropped without reset");
  chk_summary_flag: assert property ((|err_q) |=> fault_summary)
    else $error("summary flag missing");
  chk_detail_read: assert property (ar_fire && ra == dfm_pkg::OFS_DETAIL |=> rdata[N-1:0] == $past(err_q))
    else $error("detail read mismatch");
  chk_reset_blocked: assert property (wr_reset |=> ($past(err_q) & $past(cond) & ~err_q) == '0)
    else $error("reset cleared an active error");
  chk_stay_disabled: assert property ((s.drive == dfm_pkg::DRV_DISABLED) && !wr_swon && !any_err
                                      |=> s.drive == dfm_pkg::DRV_DISABLED)
    else $error("drive left disabled on its own");
  chk_follow_mask: assert property (s.mask_follow && !err_q[dfm_pkg::ERR_FOLLOW] |=> !err_q[dfm_pkg::ERR_FOLLOW])
    else $error("masked following error latched");
  chk_uv_notready: assert property (under_volt |=> !drive_ready)
    else $error("ready shown under undervoltage");
  chk_warn_shown: assert property ($rose(ot_elec) && (s.ot_elec_t != '0) |=> temp_warning[0])
    else $error("warning not shown while timer runs");
  chk_ot_qualified: assert property ($rose(err_q[dfm_pkg::ERR_OT_ELEC]) |-> $past(ot_elec, 2))
    else $error("temperature fault latched unqualified");
  chk_fieldbus_fault: assert property (fieldbus_fail |=> err_q[dfm_pkg::ERR_FIELDBUS])
    else $error("field bus fault not raised");

  cov_fault_entry: cover property (s.drive == dfm_pkg::DRV_READY ##1 s.drive == dfm_pkg::DRV_REACT);
  cov_reset_done: cover property (s.drive == dfm_pkg::DRV_FAULT ##1 s.drive == dfm_pkg::DRV_DISABLED);
  cov_warn_fault: cover property (temp_warning[0] ##[1:20] err_q[dfm_pkg::ERR_OT_ELEC]);

endmodule
`default_nettype wire

// ---- sim/dfm_host_model.sv ----
// host side model: axi4-lite master tasks for the fault manager
`timescale 1ns/10ps
`default_nettype none
module dfm_host_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // response readies stay high: every answer is taken at the edge it is seen
  initial begin
    awaddr  = 8'h00;
    awvalid = 1'h0;
    wdata   = 32'h0;
    wstrb   = 4'hF;
    wvalid  = 1'h0;
    bready  = 1'h1;
    araddr  = 8'h00;
    arvalid = 1'h0;
    rready  = 1'h1;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= dat;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    dat  = rdata;
    resp = rresp;
  endtask

  // caller removes the cause first; then reset and read the state back
  task automatic recover(output logic [31:0] st);
    logic [1:0] resp;
    wr(dfm_pkg::OFS_CTRL, 32'h1, resp);
    rd(dfm_pkg::OFS_STATE, st, resp);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_drive_fault_manager.sv ----
// self-checking bench for the drive fault manager
`timescale 1ns/10ps
`default_nettype none
module tb_drive_fault_manager;
  logic        aclk, aresetn, ce, drive_ready, fault_summary, stop_motion, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] cond;
  logic [31:0] pos_dev, wdata, rdata, d;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, temp_warning, r;
  int          miscompares, checks, cycles;
  typedef struct packed { logic [11:0] c; logic [31:0] dev; logic [11:0] e; } dfm_row_type;
  // last row sits exactly on the following-error limit: no fault
  dfm_row_type rows [8] = '{'{12'h001, 32'h0, 12'h001}, '{12'h004, 32'h0, 12'h004},
    '{12'h100, 32'h0, 12'h100}, '{12'h202, 32'h0, 12'h202}, '{12'h0B8, 32'h0, 12'h0B8},
    '{12'h000, 32'h0000_1001, 12'h040}, '{12'h000, 32'hFFFF_EFFF, 12'h040}, '{12'h000, 32'h0000_1000, 12'h000}};

  dfm_top dut (.*, .ce(ce), .under_volt(cond[0]), .over_volt(cond[1]), .over_curr(cond[2]),
    .ballast_err(cond[3]), .feedback_err(cond[4]), .i2t_err(cond[5]), .eeprom_err(cond[7]),
    .fieldbus_fail(cond[8]), .procedure_err(cond[9]), .ot_elec(cond[10]), .ot_motor(cond[11]));
  dfm_host_model host (.*);

  initial aclk = 1'h0;
  always #5 aclk = ~aclk;

  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, d, r);
    chk(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'h0;
    ce = 1'h1;
    cond = 12'h000;
    pos_dev = 32'h0;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    cyc(10);
    aresetn <= 1'h1;
    cyc(2);
    rchk(dfm_pkg::OFS_FOLLOW_LIM, dfm_pkg::FOLLOW_LIM_RST);
    rchk(dfm_pkg::OFS_OT_MOTOR_T, dfm_pkg::OT_TIME_RST);
    rchk(dfm_pkg::OFS_IRQ_MASK, 32'h0);
    rchk(dfm_pkg::OFS_STATE, 32'h1);
    host.wr(dfm_pkg::OFS_IRQ_MASK, 32'h1, r);
    $display("reset values done");
    foreach (rows[i]) begin
      host.rd(dfm_pkg::OFS_IRQ_STAT, d, r);
      cond <= rows[i].c;
      pos_dev <= rows[i].dev;
      cyc(10);
      chk(fault_summary, rows[i].e != 0);
      chk(stop_motion, rows[i].e != 0);
      chk(irq, rows[i].e != 0);
      rchk(dfm_pkg::OFS_STATE, rows[i].e != 0 ? 32'h108 : 32'h1);
      rchk(dfm_pkg::OFS_DETAIL, rows[i].e);
      rchk(dfm_pkg::OFS_IRQ_STAT, rows[i].e != 0);
      cond <= 12'h000;
      pos_dev <= 32'h0;
      cyc(3);
      rchk(dfm_pkg::OFS_DETAIL, rows[i].e);
      host.recover(d);
      chk(d, 32'h1);
      chk(irq, 1'h0);
      $display("row %0d done", i);
    end
    // undervoltage: no mask, reset refused while active
    host.wr(dfm_pkg::OFS_CTRL, 32'h2, r);
    cyc(3);
    rchk(dfm_pkg::OFS_STATE, 32'h202);
    cond <= 12'h001;
    // let the fault reaction run out so the state read sees the fault state
    cyc(8);
    chk(drive_ready, 1'h0);
    host.recover(d);
    chk(d, 32'h108);
    host.wr(dfm_pkg::OFS_CTRL, 32'h6, r);
    cyc(3);
    chk(drive_ready, 1'h0);
    rchk(dfm_pkg::OFS_DETAIL, 32'h1);
    cond <= 12'h000;
    host.recover(d);
    cyc(20);
    rchk(dfm_pkg::OFS_STATE, 32'h1);
    $display("undervoltage done");
    // the reset write above also cleared the mask bit
    host.wr(dfm_pkg::OFS_CTRL, 32'h4, r);
    rchk(dfm_pkg::OFS_CTRL, 32'h4);
    pos_dev <= 32'h0010_0000;
    cyc(10);
    chk(stop_motion, 1'h0);
    rchk(dfm_pkg::OFS_DETAIL, 32'h0);
    pos_dev <= 32'h0;
    host.wr(dfm_pkg::OFS_CTRL, 32'h0, r);
    $display("mask done");
    for (int j = 0; j < 2; j++) begin
      host.wr(dfm_pkg::OFS_OT_ELEC_T + 8'(4 * j), 32'h5, r);
      cond[10+j] <= 1'h1;
      cyc(3);
      chk(temp_warning, 2'h1 << j);
      rchk(dfm_pkg::OFS_WARN, 32'h1 << j);
      cond <= 12'h000;
      cyc(1);
      cond[10+j] <= 1'h1;
      cyc(4);
      cond <= 12'h000;
      cyc(2);
      rchk(dfm_pkg::OFS_DETAIL, 32'h0);
      cond[10+j] <= 1'h1;
      cyc(10);
      chk(temp_warning, 2'h0);
      rchk(dfm_pkg::OFS_DETAIL, 32'h400 << j);
      cond <= 12'h000;
      host.recover(d);
      chk(d, 32'h1);
    end
    $display("temperature done");
    host.rd(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, dfm_pkg::RESP_SLVERR);
    host.wr(8'h40, 32'hFFFF_FFFF, r);
    chk(r, dfm_pkg::RESP_SLVERR);
    host.wr(dfm_pkg::OFS_DETAIL, 32'hFFF, r);
    chk(r, dfm_pkg::RESP_SLVERR);
    rchk(dfm_pkg::OFS_DETAIL, 32'h0);
    $display("bus errors done");
    // clock enable low: a condition seen only then must leave no trace
    ce <= 1'h0;
    cond <= 12'h004;
    cyc(4);
    cond <= 12'h000;
    cyc(1);
    ce <= 1'h1;
    cyc(1);
    chk(fault_summary, 1'h0);
    rchk(dfm_pkg::OFS_DETAIL, 32'h0);
    $display("clock enable done");
    // reset in mid-run acts like power-off on latched errors
    cond <= 12'h004;
    cyc(3);
    aresetn <= 1'h0;
    cond <= 12'h000;
    cyc(2);
    aresetn <= 1'h1;
    cyc(2);
    chk(fault_summary, 1'h0);
    rchk(dfm_pkg::OFS_DETAIL, 32'h0);
    rchk(dfm_pkg::OFS_STATE, 32'h1);
    rchk(dfm_pkg::OFS_OT_ELEC_T, dfm_pkg::OT_TIME_RST);
    $display("mid-run reset done");
    complete_run();
  end
endmodule
`default_nettype wire
